// File: transceiver_regs_pkg.sv
`default_nettype none
package transceiver_regs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] LOW_BATTERY_CONFIG_IDX = 6'h05;
  localparam logic [5:0] LOW_BATTERY_STATUS_MAP_IDX = 6'h06;
  localparam logic [5:0] PAGE_SELECT_CONTROL_IDX = 6'h1f;
  localparam logic [5:0] IRQ_STATUS_IDX = 6'h20;
  localparam logic [5:0] IRQ_MASK_IDX = 6'h21;
  localparam logic [5:0] CRC_CONTROL_IDX = 6'h22;

  // Page codes
  localparam logic [1:0] PAGE_ZERO = 2'h0;
  localparam logic [1:0] PAGE_ONE = 2'h1;

  // Page select field positions
  localparam int PAGE_KEEP_BIT = 7;
  localparam int PAGE_DIR_BIT = 6;
  localparam int PAGE_CODE_LSB = 0;

  // Low battery field positions
  localparam int LB_ON_BIT = 3;
  localparam int LB_ABOVE_BIT = 7;
  localparam int LB_PIN_BIT = 6;

  // Interrupt bit positions
  localparam int IRQ_CRC_FAIL_BIT = 0;
  localparam int IRQ_CRC_PASS_BIT = 1;
  localparam int IRQ_BATT_LOW_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // CRC control field positions
  localparam int CRC_ENABLE_BIT = 0;
  localparam int CRC_STAT_BIT = 1;

  // Reset values
  localparam logic [7:0] PAGE_SELECT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LOW_BATTERY_CONFIG_RESET = 8'hb1;
  localparam logic [7:0] LOW_BATTERY_STATUS_MAP_RESET = 8'h96;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
endpackage
`default_nettype wire

// File: ctrl_links_if.sv
`timescale 1ns/10ps
`default_nettype none
// Low battery detector controls and results
interface lowbat_link;
  logic battery_detect_on;
  logic [2:0] battery_threshold_code;
  logic battery_result_to_pin;
  logic battery_above_threshold;
  logic low_event;
  logic pin_level;
  logic pin_oe;
  modport regs (output battery_detect_on, output battery_threshold_code,
    output battery_result_to_pin, input battery_above_threshold, input low_event,
    input pin_level, input pin_oe);
  modport det (input battery_detect_on, input battery_threshold_code,
    input battery_result_to_pin, output battery_above_threshold, output low_event,
    output pin_level, output pin_oe);
endinterface // lowbat_link

// Receive CRC outcome and FIFO clear
interface crc_link;
  logic receiving;
  logic check_done;
  logic check_ok;
  logic crc_enable;
  logic crc_fail_fifo_keep;
  logic fifo_clear;
  logic fail_event;
  logic pass_event;
  modport regs (output receiving, output check_done, output check_ok,
    output crc_enable, output crc_fail_fifo_keep, input fifo_clear,
    input fail_event, input pass_event);
  modport ctl (input receiving, input check_done, input check_ok,
    input crc_enable, input crc_fail_fifo_keep, output fifo_clear,
    output fail_event, output pass_event);
endinterface // crc_link
`default_nettype wire

// File: crc_fifo_clear.sv
`timescale 1ns/10ps
`default_nettype none
module crc_fifo_clear (
  input wire logic clock,
  input wire logic rst_b,
  crc_link.ctl link
);
  logic fifo_clear;
  logic fail_event;
  logic pass_event;
  logic next_fifo_clear;
  logic next_fail_event;
  logic next_pass_event;

  // Outcome only counts while CRC processing is on; FIFO clear also needs a frame being received
  always_comb begin
    next_pass_event = link.check_done && link.crc_enable && link.check_ok;
    next_fail_event = link.check_done && link.crc_enable && !link.check_ok;
    next_fifo_clear = next_fail_event && link.receiving && !link.crc_fail_fifo_keep;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fifo_clear <= 1'b0;
      fail_event <= 1'b0;
      pass_event <= 1'b0;
    end else begin
      fifo_clear <= next_fifo_clear;
      fail_event <= next_fail_event;
      pass_event <= next_pass_event;
    end
  end

  assign link.fifo_clear = fifo_clear;
  assign link.fail_event = fail_event;
  assign link.pass_event = pass_event;
endmodule // crc_fifo_clear
`default_nettype wire

// File: battery_detect.sv
`timescale 1ns/10ps
`default_nettype none
module battery_detect (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic compare_raw,
  lowbat_link.det link
);
  logic sync_first;
  logic sync_second;
  logic above;
  logic low_event;
  logic pin_level;
  logic pin_oe;
  logic next_above;
  logic next_low_event;
  logic next_pin_level;
  logic next_pin_oe;

  // Comparator is analog and asynchronous: two flops before use
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first <= compare_raw;
      sync_second <= sync_first;
    end
  end

  // Off detector reports below; low event on a falling result while on
  always_comb begin
    next_above = link.battery_detect_on && sync_second;
    next_low_event = link.battery_detect_on && above && !sync_second;
    next_pin_oe = link.battery_result_to_pin;
    next_pin_level = link.battery_result_to_pin && link.battery_detect_on && !sync_second;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      above <= 1'b0;
      low_event <= 1'b0;
      pin_level <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      above <= next_above;
      low_event <= next_low_event;
      pin_level <= next_pin_level;
      pin_oe <= next_pin_oe;
    end
  end

  assign link.battery_above_threshold = above;
  assign link.low_event = low_event;
  assign link.pin_level = pin_level;
  assign link.pin_oe = pin_oe;
endmodule // battery_detect
`default_nettype wire

// File: page_select_low_battery_regs.sv
// Notes on behaviour
// - Failing CRC on receive clears the FIFO unless the keep bit is set.
// - In standby, direction bit picks FIFO write (0) or read (1).
// - Page code 00 selects page zero, 01 page one; others unused.
// - Page select register decodes at the same address in every page.
// - Low battery registers sit at 0x05 and 0x06 of page one only.
// - Detector enable bit switches battery detection on and off.
// - Three threshold bits pick one of eight rising thresholds.
// - Status bit 7 is read-only: 1 above threshold, 0 below.
// - Mapping bit routes the detection result to the output pin.
// - CRC outcome counts only when enabled; pass flag clears by writing one.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module page_select_low_battery_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby,
  input wire logic receiving,
  input wire logic crc_check_done,
  input wire logic crc_check_ok,
  output logic rx_fifo_clear,
  output logic fifo_direction_select,
  output logic fifo_read_access,
  input wire logic battery_compare_raw,
  output logic battery_detect_on,
  output logic [2:0] battery_threshold_code,
  output logic battery_pin_out,
  output logic battery_pin_oe,
  output logic irq
);
  lowbat_link lb ();
  crc_link cl ();

  logic [7:0] page_ctrl;
  logic [7:0] lb_config;
  logic [6:0] lb_map;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic crc_enable;
  logic crc_stat;
  logic [31:0] read_data;
  logic fifo_read;
  logic [7:0] next_page_ctrl;
  logic [7:0] next_lb_config;
  logic [6:0] next_lb_map;
  logic [2:0] next_irq_status;
  logic [2:0] next_irq_mask;
  logic next_crc_enable;
  logic next_crc_stat;
  logic [31:0] next_read_data;
  logic next_fifo_read;
  logic [5:0] index;
  logic aligned;
  logic setup_phase;
  logic write_strobe;
  logic page_one;
  logic hit_page;
  logic hit_config;
  logic hit_map;
  logic hit_status;
  logic hit_mask;
  logic hit_crc;
  logic [2:0] irq_events;

  // Sticky flag: a set in the clearing cycle wins
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  crc_fifo_clear u_crc (
    .clock(clock),
    .rst_b(rst_b),
    .link(cl.ctl)
  );

  battery_detect u_batt (
    .clock(clock),
    .rst_b(rst_b),
    .compare_raw(battery_compare_raw),
    .link(lb.det)
  );

  // Address decode; page select and own registers answer in every page
  always_comb begin
    index = paddr[7:2];
    aligned = (paddr[1:0] == 2'h0);
    page_one = (page_ctrl[1:0] == transceiver_regs_pkg::PAGE_ONE);
    hit_page = aligned && (index == transceiver_regs_pkg::PAGE_SELECT_CONTROL_IDX);
    hit_config = aligned && page_one &&
      (index == transceiver_regs_pkg::LOW_BATTERY_CONFIG_IDX);
    hit_map = aligned && page_one &&
      (index == transceiver_regs_pkg::LOW_BATTERY_STATUS_MAP_IDX);
    hit_status = aligned && (index == transceiver_regs_pkg::IRQ_STATUS_IDX);
    hit_mask = aligned && (index == transceiver_regs_pkg::IRQ_MASK_IDX);
    hit_crc = aligned && (index == transceiver_regs_pkg::CRC_CONTROL_IDX);
    setup_phase = psel && !penable;
    write_strobe = psel && penable && pwrite;
  end

  // Events that feed the sticky interrupt status
  always_comb begin
    irq_events = 3'h0;
    irq_events[transceiver_regs_pkg::IRQ_CRC_FAIL_BIT] = cl.fail_event;
    irq_events[transceiver_regs_pkg::IRQ_CRC_PASS_BIT] = cl.pass_event;
    irq_events[transceiver_regs_pkg::IRQ_BATT_LOW_BIT] = lb.low_event;
  end

  // Register next values; host writes land in the access cycle
  always_comb begin
    next_page_ctrl = page_ctrl;
    next_lb_config = lb_config;
    next_lb_map = lb_map;
    next_irq_mask = irq_mask;
    next_crc_enable = crc_enable;
    next_irq_status = irq_status;
    next_crc_stat = crc_stat;
    if (write_strobe && hit_page) begin
      // Unused bits 5..2 stay zero
      next_page_ctrl = {pwdata[7:6], 4'h0, pwdata[1:0]};
    end
    if (write_strobe && hit_config) begin
      // Reserved nibble stored as written; keeping it is up to the host
      next_lb_config = pwdata[7:0];
    end
    if (write_strobe && hit_map) begin
      // Bit 7 is a live readout and ignores writes
      next_lb_map = pwdata[6:0];
    end
    if (write_strobe && hit_mask) begin
      next_irq_mask = pwdata[2:0];
    end
    if (write_strobe && hit_crc) begin
      next_crc_enable = pwdata[transceiver_regs_pkg::CRC_ENABLE_BIT];
    end
    for (int i = 0; i < transceiver_regs_pkg::IRQ_WIDTH; i++) begin
      next_irq_status[i] = sticky(irq_status[i], irq_events[i],
        write_strobe && hit_status && pwdata[i]);
    end
    next_crc_stat = sticky(crc_stat, cl.pass_event,
      write_strobe && hit_crc && pwdata[transceiver_regs_pkg::CRC_STAT_BIT]);
  end

  // Read data is captured in the setup cycle so it stands through access
  always_comb begin
    next_read_data = prdata;
    if (setup_phase) begin
      next_read_data = 32'h0;
      if (hit_page) begin
        next_read_data[7:0] = page_ctrl;
      end else if (hit_config) begin
        next_read_data[7:0] = lb_config;
      end else if (hit_map) begin
        next_read_data[7:0] = {lb.battery_above_threshold, lb_map};
      end else if (hit_status) begin
        next_read_data[2:0] = irq_status;
      end else if (hit_mask) begin
        next_read_data[2:0] = irq_mask;
      end else if (hit_crc) begin
        next_read_data[transceiver_regs_pkg::CRC_ENABLE_BIT] = crc_enable;
        next_read_data[transceiver_regs_pkg::CRC_STAT_BIT] = crc_stat;
      end
    end
  end

  // Host FIFO direction only applies in standby
  always_comb begin
    next_fifo_read = standby && page_ctrl[transceiver_regs_pkg::PAGE_DIR_BIT];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      page_ctrl <= transceiver_regs_pkg::PAGE_SELECT_CONTROL_RESET;
      lb_config <= transceiver_regs_pkg::LOW_BATTERY_CONFIG_RESET;
      lb_map <= transceiver_regs_pkg::LOW_BATTERY_STATUS_MAP_RESET[6:0];
      irq_status <= 3'h0;
      irq_mask <= transceiver_regs_pkg::IRQ_MASK_RESET;
      crc_enable <= 1'b0;
      crc_stat <= 1'b0;
      prdata <= 32'h0;
      fifo_read <= 1'b0;
    end else begin
      page_ctrl <= next_page_ctrl;
      lb_config <= next_lb_config;
      lb_map <= next_lb_map;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      crc_enable <= next_crc_enable;
      crc_stat <= next_crc_stat;
      prdata <= next_read_data;
      fifo_read <= next_fifo_read;
    end
  end

  // Controls out to the sub-blocks
  assign lb.battery_detect_on = lb_config[transceiver_regs_pkg::LB_ON_BIT];
  assign lb.battery_threshold_code = lb_config[2:0];
  assign lb.battery_result_to_pin = lb_map[transceiver_regs_pkg::LB_PIN_BIT];
  assign cl.receiving = receiving;
  assign cl.check_done = crc_check_done;
  assign cl.check_ok = crc_check_ok;
  assign cl.crc_enable = crc_enable;
  assign cl.crc_fail_fifo_keep = page_ctrl[transceiver_regs_pkg::PAGE_KEEP_BIT];

  // Zero-wait slave; unmapped reads give zero, no error
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign rx_fifo_clear = cl.fifo_clear;
  assign fifo_direction_select = page_ctrl[transceiver_regs_pkg::PAGE_DIR_BIT];
  assign fifo_read_access = fifo_read;
  assign battery_detect_on = lb_config[transceiver_regs_pkg::LB_ON_BIT];
  assign battery_threshold_code = lb_config[2:0];
  assign battery_pin_out = lb.pin_level;
  assign battery_pin_oe = lb.pin_oe;
  assign irq = |(irq_status & irq_mask);
endmodule // page_select_low_battery_regs
`default_nettype wire

// File: page_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module page_regs_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic standby,
  input wire logic receiving,
  input wire logic crc_check_done,
  input wire logic crc_check_ok,
  input wire logic rx_fifo_clear,
  input wire logic fifo_direction_select,
  input wire logic fifo_read_access,
  input wire logic battery_detect_on,
  input wire logic [2:0] battery_threshold_code,
  input wire logic battery_pin_out,
  input wire logic battery_pin_oe,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Completed write cycle; register changes must trace back to one
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;

  chk_read_dir_lag: assert property (fifo_read_access == $past(standby && fifo_direction_select))
    else $error("fifo read access does not follow standby and direction");
  chk_clear_cause: assert property (rx_fifo_clear |-> $past(crc_check_done && !crc_check_ok && receiving))
    else $error("fifo clear without a failed check in reception");
  chk_pin_mapped: assert property (battery_pin_out |-> battery_pin_oe)
    else $error("pin driven while not mapped");
  chk_pin_detect_off: assert property (!battery_detect_on |=> !battery_pin_out)
    else $error("pin active with detection off");
  chk_dir_write: assert property ($changed(fifo_direction_select) |-> $past(wr_acc && paddr == 8'h7c))
    else $error("direction changed without page register write");
  chk_thr_write: assert property ($changed(battery_threshold_code) |-> $past(wr_acc && paddr == 8'h14))
    else $error("threshold changed without config write");
  chk_on_write: assert property ($changed(battery_detect_on) |-> $past(wr_acc && paddr == 8'h14))
    else $error("detect enable changed without config write");
  chk_zero_wait: assert property (psel && penable |-> pready && !pslverr)
    else $error("access not answered at once without error");

  cover property (rx_fifo_clear);
  cover property (irq);
  cover property (battery_pin_out);
  cover property (fifo_read_access);
endmodule // page_regs_props

bind page_select_low_battery_regs page_regs_props chk (.clock, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .standby, .receiving, .crc_check_done, .crc_check_ok,
  .rx_fifo_clear, .fifo_direction_select, .fifo_read_access, .battery_detect_on,
  .battery_threshold_code, .battery_pin_out, .battery_pin_oe, .irq);
`default_nettype wire

// File: host_apb.sv
`timescale 1ns/10ps
`default_nettype none
module host_apb (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  // Shadow of page bits 7:6 so page switching keeps them
  logic [1:0] hi = 2'h0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic pg_wr(input logic [1:0] h, input logic [1:0] code);
    hi = h;
    wr(8'h7c, {24'h0, h, 4'h0, code});
  endtask
  // Page one is left at once, so stray page-zero traffic never lands there
  task automatic p1_wr(input logic [7:0] a, input logic [31:0] d);
    pg_wr(hi, 2'h1);
    wr(a, d);
    pg_wr(hi, 2'h0);
  endtask
  task automatic p1_rd(input logic [7:0] a, output logic [31:0] d);
    pg_wr(hi, 2'h1);
    rd(a, d);
    pg_wr(hi, 2'h0);
  endtask
  task automatic cfg_wr(input logic on, input logic [2:0] t);
    p1_wr(8'h14, {24'h0, 4'hb, on, t});
  endtask
  task automatic map_wr(input logic m);
    p1_wr(8'h18, {24'h0, 1'b0, m, 6'h16});
  endtask
endmodule // host_apb
`default_nettype wire

// File: page_select_low_battery_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module page_select_low_battery_regs_tb;
  logic clock, rst_b, psel, penable, pwrite, standby, receiving, done, ok, raw;
  logic pready, pslverr, clr, dir, rdacc, on, pin, oe, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [2:0] thr;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  page_select_low_battery_regs dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .standby, .receiving, .crc_check_done(done),
    .crc_check_ok(ok), .rx_fifo_clear(clr), .fifo_direction_select(dir),
    .fifo_read_access(rdacc), .battery_compare_raw(raw), .battery_detect_on(on),
    .battery_threshold_code(thr), .battery_pin_out(pin), .battery_pin_oe(oe), .irq);
  host_apb host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  // Compare task; case inequality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] g;
    host.rd(a, g);
    chk("prdata", e, g);
  endtask
  // Check pulse in reception; clear is looked at in its single cycle
  task automatic crc(input logic k, input logic e);
    @(posedge clock);
    done <= 1'b1;
    ok <= k;
    @(posedge clock);
    done <= 1'b0;
    #1 chk("rx_fifo_clear", {31'h0, e}, clr);
  endtask
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard, far above the roughly 140 cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    rst_b = 1'b0;
    standby = 1'b0;
    receiving = 1'b0;
    done = 1'b0;
    ok = 1'b0;
    raw = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rdc(8'h7c, 32'h0);
    host.wr(8'h7c, 32'h1);
    rdc(8'h7c, 32'h1);
    rdc(8'h14, 32'hb1);
    rdc(8'h18, 32'h16);
    rdc(8'h1c, 32'h0);
    host.wr(8'h7c, 32'hff);
    rdc(8'h7c, 32'hc3);
    rdc(8'h14, 32'h0);
    host.wr(8'h7c, 32'h0);
    rdc(8'h18, 32'h0);
    host.wr(8'h7c, 32'h40);
    #1 chk("fifo_direction_select", 32'h1, dir);
    standby <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("fifo_read_access", 32'h1, rdacc);
    host.wr(8'h7c, 32'h0);
    repeat (2) @(posedge clock);
    #1 chk("fifo_read_access", 32'h0, rdacc);
    host.cfg_wr(1'b1, 3'h3);
    chk("battery_detect_on", 32'h1, on);
    chk("battery_threshold_code", 32'h3, thr);
    host.map_wr(1'b1);
    raw <= 1'b1;
    host.p1_rd(8'h18, d);
    chk("low_battery_status_map", 32'hd6, d);
    #1 chk("battery_pin_out", 32'h0, pin);
    chk("battery_pin_oe", 32'h1, oe);
    @(posedge clock);
    raw <= 1'b0;
    host.p1_wr(8'h18, 32'hd6);
    host.p1_rd(8'h18, d);
    chk("low_battery_status_map", 32'h56, d);
    #1 chk("battery_pin_out", 32'h1, pin);
    rdc(8'h80, 32'h4);
    host.wr(8'h84, 32'h4);
    #1 chk("irq", 32'h1, irq);
    host.wr(8'h80, 32'h4);
    #1 chk("irq", 32'h0, irq);
    host.cfg_wr(1'b0, 3'h7);
    chk("battery_threshold_code", 32'h7, thr);
    #1 chk("battery_pin_out", 32'h0, pin);
    host.wr(8'h88, 32'h1);
    receiving <= 1'b1;
    crc(1'b0, 1'b1);
    crc(1'b1, 1'b0);
    rdc(8'h88, 32'h3);
    host.wr(8'h88, 32'h3);
    rdc(8'h88, 32'h1);
    host.pg_wr(2'h2, 2'h0);
    crc(1'b0, 1'b0);
    host.pg_wr(2'h0, 2'h0);
    host.wr(8'h88, 32'h0);
    crc(1'b0, 1'b0);
    rdc(8'h80, 32'h3);
    complete_run;
  end
endmodule // page_select_low_battery_regs_tb
`default_nettype wire
